/* hdl/sirp_pkg.sv */
package sirp_pkg;
	// target address on the bus (arbitrary value)
	localparam logic [6:0] SIRP_TARGET_ADDR = 7'h2a;
	// register map
	localparam logic [7:0] SIRP_REG_PART_ID    = 8'h00;
	localparam logic [7:0] SIRP_REG_BOARD_REV  = 8'h01;
	localparam logic [7:0] SIRP_REG_FW_MAJOR   = 8'h02;
	localparam logic [7:0] SIRP_REG_FW_MINOR   = 8'h03;
	localparam logic [7:0] SIRP_REG_RATE       = 8'h04;
	localparam logic [7:0] SIRP_REG_ACCEL_FS   = 8'h05;
	localparam logic [7:0] SIRP_REG_GYRO_FS_LO = 8'h06;
	localparam logic [7:0] SIRP_REG_GYRO_FS_HI = 8'h07;
	localparam logic [7:0] SIRP_REG_OP_STATE   = 8'h08;
	localparam logic [7:0] SIRP_REG_CAL_STATE  = 8'h09;
	localparam logic [7:0] SIRP_REG_SELFTEST   = 8'h0a;
	localparam logic [7:0] SIRP_REG_FLAGS_LO   = 8'h0b;
	localparam logic [7:0] SIRP_REG_FLAGS_HI   = 8'h0c;
	localparam logic [7:0] SIRP_REG_STAMP0     = 8'h10;
	localparam logic [7:0] SIRP_REG_STAMP3     = 8'h13;
	localparam logic [7:0] SIRP_REG_LAST       = 8'h13;
	// identity values (arbitrary)
	localparam logic [7:0] SIRP_PART_ID        = 8'h5a;
	localparam logic [7:0] SIRP_BOARD_REV      = 8'h01;
	localparam logic [7:0] SIRP_FW_MAJOR       = 8'h01;
	localparam logic [7:0] SIRP_FW_MINOR       = 8'h00;
	localparam logic [7:0] SIRP_RATE_RST       = 8'h32;
	localparam logic [7:0] SIRP_ACCEL_FS       = 8'h02;
	localparam logic [15:0] SIRP_GYRO_FS       = 16'h07d0;
	// controller registers (word index on the plain port)
	localparam logic [3:0] SIRP_C_CTRL   = 4'h0;
	localparam logic [3:0] SIRP_C_TX     = 4'h1;
	localparam logic [3:0] SIRP_C_RX     = 4'h2;
	localparam logic [3:0] SIRP_C_STAT   = 4'h3;
	localparam logic [3:0] SIRP_C_CLR    = 4'h4;
	localparam logic [3:0] SIRP_C_IEN    = 4'h5;
	localparam logic [3:0] SIRP_C_DIV    = 4'h6;
	// ctrl bits: 0 start, 1 stop, 2 write byte, 3 read byte, 4 nack on read
	localparam int SIRP_ST_DONE  = 0;
	localparam int SIRP_ST_NACK  = 1;
	localparam int SIRP_ST_BUSY  = 2;
	// link timing: 400 kHz -> 2500 ns period, quarter 625 ns
	localparam int SIRP_CLK_NS     = 8;
	localparam int SIRP_SCL_MIN_NS = 2500;
	localparam int SIRP_QTR_CYC    = (SIRP_SCL_MIN_NS / 4 + SIRP_CLK_NS - 1)
		/ SIRP_CLK_NS;
	localparam logic [15:0] SIRP_DIV_RST = 16'(SIRP_QTR_CYC);
endpackage

/* hdl/sirp_if.sv */
`timescale 1ns/1ps
interface sirp_if;
	logic scl_o;
	logic scl_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_t_o;
	logic sda_t_oe;
	wire  scl = scl_oe ? scl_o : 1'b1;
	wire  sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_t_oe ? sda_t_o : 1'b1);
	modport host (output scl_o, scl_oe, sda_m_o, sda_m_oe, input scl, sda);
	modport target (output sda_t_o, sda_t_oe, input scl, sda);
endinterface

/* hdl/sirp_target.sv */
`timescale 1ns/1ps
// How it works
// - answer only our own 7-bit address
// - sampling keeps up with 400 kHz
// - address bit set means write, clear read
// - first written byte sets register pointer
// - reads auto-increment, stop at last register
// - value after pointer byte is written
// - wide values least significant byte first
// - signed quantities are two's complement
// - hundredths: value times 100, rounded
// - thousandths: value times 1000, rounded
// - pi radians: value times 16384, rounded
// - any register readable at any time
// - timestamp advances on each new sample
// - master compares timestamp step to period
module sirp_target
	import sirp_pkg::*;
(
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       RST,
	// link
	sirp_if.target          LINK,
	// sample side
	input  wire logic       SAMPLE_STB,
	input  wire logic [7:0] OP_STATE,
	input  wire logic [7:0] CAL_STATE,
	input  wire logic [7:0] SELFTEST,
	input  wire logic [15:0] FLAGS,
	output logic      [7:0] RATE_HZ
);
	typedef enum {T_IDLE, T_ADDR, T_ACK, T_RX, T_TX, T_TXACK, T_SKIP}
		sirp_tst_t;
	sirp_tst_t   state_q;
	logic [2:0]  scl_s_q;
	logic [2:0]  sda_s_q;
	logic [3:0]  bit_q;
	logic [7:0]  sh_q;
	logic        rw_q;
	logic        have_ptr_q;
	logic [7:0]  ptr_q;
	logic [7:0]  rate_q;
	logic [31:0] stamp_q;
	logic        drive_q;
	logic        scl_r;
	logic        scl_f;
	logic        start_c;
	logic        stop_c;
	logic [7:0]  rd_c;

	always_ff @(posedge CLK or posedge RST)
		if (RST)
		begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
		end
		else
		begin
			scl_s_q <= {scl_s_q[1:0], LINK.scl};
			sda_s_q <= {sda_s_q[1:0], LINK.sda};
		end
	assign scl_r   = scl_s_q[1] & ~scl_s_q[2];
	assign scl_f   = ~scl_s_q[1] & scl_s_q[2];
	assign start_c = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
	assign stop_c  = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];

	function automatic logic [7:0] rd(input logic [7:0] a);
		unique case (a)
			SIRP_REG_PART_ID:    rd = SIRP_PART_ID;
			SIRP_REG_BOARD_REV:  rd = SIRP_BOARD_REV;
			SIRP_REG_FW_MAJOR:   rd = SIRP_FW_MAJOR;
			SIRP_REG_FW_MINOR:   rd = SIRP_FW_MINOR;
			SIRP_REG_RATE:       rd = rate_q;
			SIRP_REG_ACCEL_FS:   rd = SIRP_ACCEL_FS;
			SIRP_REG_GYRO_FS_LO: rd = SIRP_GYRO_FS[7:0];
			SIRP_REG_GYRO_FS_HI: rd = SIRP_GYRO_FS[15:8];
			SIRP_REG_OP_STATE:   rd = OP_STATE;
			SIRP_REG_CAL_STATE:  rd = CAL_STATE;
			SIRP_REG_SELFTEST:   rd = SELFTEST;
			SIRP_REG_FLAGS_LO:   rd = FLAGS[7:0];
			SIRP_REG_FLAGS_HI:   rd = FLAGS[15:8];
			SIRP_REG_STAMP0:     rd = stamp_q[7:0];
			SIRP_REG_STAMP0 + 8'h01: rd = stamp_q[15:8];
			SIRP_REG_STAMP0 + 8'h02: rd = stamp_q[23:16];
			SIRP_REG_STAMP3:     rd = stamp_q[31:24];
			default:             rd = 8'h00;
		endcase
	endfunction

	// byte at the pointer, ready for the next read slot
	always_comb
		rd_c = rd(ptr_q);

	always_ff @(posedge CLK or posedge RST)
		if (RST)
			stamp_q <= 32'h0000_0000;
		else if (SAMPLE_STB)
			stamp_q <= stamp_q + 32'h0000_0001;

	// link protocol
	always_ff @(posedge CLK or posedge RST)
		if (RST)
		begin
			state_q    <= T_IDLE;
			bit_q      <= 4'h0;
			sh_q       <= 8'h00;
			rw_q       <= 1'b0;
			have_ptr_q <= 1'b0;
			ptr_q      <= 8'h00;
			rate_q     <= SIRP_RATE_RST;
			drive_q    <= 1'b0;
		end
		else if (start_c)
		begin
			state_q    <= T_ADDR;
			bit_q      <= 4'h0;
			have_ptr_q <= 1'b0;
			drive_q    <= 1'b0;
		end
		else if (stop_c)
		begin
			state_q <= T_IDLE;
			drive_q <= 1'b0;
		end
		else
			unique case (state_q)
				T_IDLE, T_SKIP: drive_q <= 1'b0;
				T_ADDR, T_RX:
					if (scl_r)
					begin
						sh_q  <= {sh_q[6:0], sda_s_q[1]};
						bit_q <= bit_q + 4'h1;
					end
					else if (scl_f && bit_q == 4'h8)
					begin
						bit_q <= 4'h0;
						if (state_q == T_ADDR)
						begin
							// address match, bit set means write
							if (sh_q[7:1] == SIRP_TARGET_ADDR)
							begin
								rw_q    <= sh_q[0];
								drive_q <= 1'b1;
								state_q <= T_ACK;
							end
							else
								state_q <= T_SKIP;
						end
						else
						begin
							drive_q <= 1'b1;
							state_q <= T_ACK;
							if (!have_ptr_q)
							begin
								ptr_q      <= sh_q;
								have_ptr_q <= 1'b1;
							end
							else
							begin
								if (ptr_q == SIRP_REG_RATE)
									rate_q <= sh_q;
								if (ptr_q != SIRP_REG_LAST)
									ptr_q <= ptr_q + 8'h01;
							end
						end
					end
				T_ACK:
					if (scl_f)
					begin
						if (rw_q)
						begin
							drive_q <= 1'b0;
							state_q <= T_RX;
						end
						else
						begin
							sh_q    <= rd_c;
							drive_q <= ~rd_c[7];
							state_q <= T_TX;
						end
					end
				T_TX:
					if (scl_f)
					begin
						if (bit_q == 4'h7)
						begin
							bit_q   <= 4'h0;
							drive_q <= 1'b0;
							state_q <= T_TXACK;
						end
						else
						begin
							bit_q   <= bit_q + 4'h1;
							sh_q    <= {sh_q[6:0], 1'b0};
							drive_q <= ~sh_q[6];
						end
					end
				T_TXACK:
					if (scl_r)
					begin
						// burst on ack, hold at last
						if (sda_s_q[1])
							state_q <= T_SKIP;
						else
						begin
							if (ptr_q != SIRP_REG_LAST)
								ptr_q <= ptr_q + 8'h01;
							state_q <= T_ACK;
							rw_q    <= 1'b0;
						end
					end
				default: state_q <= T_IDLE;
			endcase

	assign LINK.sda_t_o  = 1'b0;
	assign LINK.sda_t_oe = drive_q;
	assign RATE_HZ       = rate_q;
endmodule // sirp_target

/* hdl/sirp_host.sv */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module sirp_host
	import sirp_pkg::*;
(
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// register port
	input  wire logic [3:0]  ADDR,
	input  wire logic [15:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [15:0] RDATA,
	output logic             IRQ,
	// link
	sirp_if.host             LINK
);
	typedef enum {H_IDLE, H_START, H_BIT, H_ACK, H_STOP} sirp_hst_t;
	sirp_hst_t   state_q;
	logic [1:0]  sda_s_q;
	logic [15:0] div_q;
	logic [15:0] cnt_q;
	logic [1:0]  ph_q;
	logic [2:0]  bit_q;
	logic [7:0]  tx_q;
	logic [7:0]  rx_q;
	logic        rd_q;
	logic        nack_cfg_q;
	logic        nack_q;
	logic        stop_q;
	logic        byte_q;
	logic [1:0]  stat_q;
	logic [1:0]  ien_q;
	logic        scl_q;
	logic        sda_q;
	logic        tick;
	logic        done_p;
	logic        nack_p;
	logic        cmd;

	// data line sync; the host never reads back its own clock
	always_ff @(posedge CLK or posedge RST)
		if (RST)
			sda_s_q <= 2'h3;
		else
			sda_s_q <= {sda_s_q[0], LINK.sda};

	// quarter-period enable
	always_ff @(posedge CLK or posedge RST)
		if (RST)
			cnt_q <= 16'h0000;
		else if (state_q == H_IDLE || cnt_q == div_q)
			cnt_q <= 16'h0000;
		else
			cnt_q <= cnt_q + 16'h0001;
	assign tick = state_q != H_IDLE && cnt_q == div_q;
	assign cmd  = WR && ADDR == SIRP_C_CTRL && state_q == H_IDLE;

	always_ff @(posedge CLK or posedge RST)
		if (RST)
		begin
			div_q <= SIRP_DIV_RST;
			tx_q  <= 8'h00;
			ien_q <= 2'h0;
		end
		else if (WR)
		begin
			if (ADDR == SIRP_C_DIV && WDATA != 16'h0000)
				div_q <= WDATA;
			if (ADDR == SIRP_C_TX)
				tx_q <= WDATA[7:0];
			if (ADDR == SIRP_C_IEN)
				ien_q <= WDATA[1:0];
		end

	// sticky status, set wins over clear
	always_ff @(posedge CLK or posedge RST)
		if (RST)
			stat_q <= 2'h0;
		else
			stat_q <= (stat_q & ~((WR && ADDR == SIRP_C_CLR) ? WDATA[1:0] : 2'h0))
				| {nack_p, done_p};
	assign IRQ = |(stat_q & ien_q);

	always_ff @(posedge CLK or posedge RST)
		if (RST)
			RDATA <= 16'h0000;
		else if (RD)
			unique case (ADDR)
				SIRP_C_RX:   RDATA <= {8'h00, rx_q};
				SIRP_C_STAT: RDATA <= {13'h0000, state_q != H_IDLE, stat_q};
				SIRP_C_IEN:  RDATA <= {14'h0000, ien_q};
				SIRP_C_DIV:  RDATA <= div_q;
				default:     RDATA <= 16'h0000;
			endcase
		else
			RDATA <= 16'h0000;

	// byte engine; software sequences address, pointer, data
	always_ff @(posedge CLK or posedge RST)
		if (RST)
		begin
			state_q    <= H_IDLE;
			ph_q       <= 2'h0;
			bit_q      <= 3'h0;
			rx_q       <= 8'h00;
			rd_q       <= 1'b0;
			nack_cfg_q <= 1'b0;
			nack_q     <= 1'b0;
			stop_q     <= 1'b0;
			byte_q     <= 1'b0;
			scl_q      <= 1'b1;
			sda_q      <= 1'b1;
			done_p     <= 1'b0;
			nack_p     <= 1'b0;
		end
		else
		begin
			done_p <= 1'b0;
			nack_p <= 1'b0;
			if (cmd)
			begin
				ph_q       <= 2'h0;
				bit_q      <= 3'h7;
				rd_q       <= WDATA[3];
				nack_cfg_q <= WDATA[4];
				stop_q     <= WDATA[1];
				byte_q     <= WDATA[3] | WDATA[2];
				if (WDATA[0])
					state_q <= H_START;
				else if (WDATA[3] || WDATA[2])
					state_q <= H_BIT;
				else if (WDATA[1])
					state_q <= H_STOP;
			end
			else if (tick)
			begin
				ph_q <= ph_q + 2'h1;
				unique case (state_q)
					H_START:
						unique case (ph_q)
							2'h0:
							begin
								sda_q <= 1'b1;
								scl_q <= 1'b1;
							end
							2'h1: sda_q <= 1'b0;
							2'h2: scl_q <= 1'b0;
							// bare start ends here or goes to a stop
							2'h3:
								if (byte_q)
									state_q <= H_BIT;
								else if (stop_q)
									state_q <= H_STOP;
								else
								begin
									done_p  <= 1'b1;
									state_q <= H_IDLE;
								end
						endcase
					H_BIT, H_ACK:
						unique case (ph_q)
							2'h0:
								sda_q <= state_q == H_ACK ? (rd_q ? nack_cfg_q : 1'b1)
									: (rd_q ? 1'b1 : tx_q[bit_q]);
							2'h1: scl_q <= 1'b1;
							2'h2:
								if (state_q == H_ACK)
									nack_q <= rd_q ? nack_cfg_q : sda_s_q[1];
								else
									rx_q <= {rx_q[6:0], sda_s_q[1]};
							2'h3:
							begin
								scl_q <= 1'b0;
								if (state_q == H_BIT)
								begin
									bit_q <= bit_q - 3'h1;
									if (bit_q == 3'h0)
										state_q <= H_ACK;
								end
								else
								begin
									done_p  <= 1'b1;
									nack_p  <= nack_q;
									state_q <= stop_q ? H_STOP : H_IDLE;
								end
							end
						endcase
					H_STOP:
						unique case (ph_q)
							2'h0: sda_q <= 1'b0;
							2'h1: scl_q <= 1'b1;
							2'h2: sda_q <= 1'b1;
							2'h3:
							begin
								done_p  <= 1'b1;
								state_q <= H_IDLE;
							end
						endcase
					default: state_q <= H_IDLE;
				endcase
			end
		end

	// open drain: drive only lows
	assign LINK.scl_o    = 1'b0;
	assign LINK.scl_oe   = ~scl_q;
	assign LINK.sda_m_o  = 1'b0;
	assign LINK.sda_m_oe = ~sda_q;
endmodule // sirp_host

/* dv/sirp_asserts.sv */
`timescale 1ns/1ps
module sirp_asserts
	import sirp_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// link
	input wire logic scl_oe,
	input wire logic sda_m_o,
	input wire logic sda_m_oe,
	input wire logic sda_t_o,
	input wire logic sda_t_oe,
	input wire logic scl,
	input wire logic sda
);
	logic       scl_q;
	logic       sda_q;
	logic       frst_q;
	logic       rw_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic [8:0] per_q;
	wire        rise = scl && !scl_q;
	wire        strt = scl && scl_q && sda_q && !sda;
	wire        ack = rise && bit_q == 4'h8;
	wire        hit = sh_q[7:1] == SIRP_TARGET_ADDR;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (RST);
	always_ff @(posedge CLK or posedge RST)
		if (RST)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			per_q <= 9'h1ff;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
			per_q <= rise ? 9'h000 : per_q + 9'(per_q != 9'h1ff);
		end
	// bit position within the current byte
	always_ff @(posedge CLK or posedge RST)
		if (RST)
		begin
			bit_q <= 4'h0;
			frst_q <= 1'b0;
			rw_q <= 1'b0;
			sh_q <= 8'h00;
		end
		else if (strt)
		begin
			bit_q <= 4'h0;
			frst_q <= 1'b1;
		end
		else if (ack)
		begin
			bit_q <= 4'h0;
			frst_q <= 1'b0;
			rw_q <= frst_q ? sh_q[0] : rw_q;
		end
		else if (rise)
		begin
			bit_q <= bit_q + 4'h1;
			sh_q <= {sh_q[6:0], sda};
		end
	rst_release_a: assert property ($fell(RST) |-> !sda_t_oe && !sda_m_oe
		&& !scl_oe) else $error("link driven after reset");
	own_addr_ack_a: assert property (ack && frst_q && hit |->
		(sda_t_oe && !sda_t_o) [*8]) else $error("own address not acked");
	other_addr_a: assert property (ack && frst_q && !hit |->
		!sda_t_oe) else $error("foreign address acked");
	write_quiet_a: assert property (rise && bit_q != 4'h8 &&
		(frst_q || rw_q) |-> !sda_t_oe) else $error("target drove data");
	read_ack_a: assert property (ack && !frst_q && !rw_q |->
		!sda_t_oe) else $error("target held read ack slot");
	host_ack_a: assert property (ack && (frst_q || rw_q) |->
		!sda_m_oe || sda_m_o) else $error("host held write ack slot");
	// data bit periods at least 312 cycles
	scl_period_a: assert property (rise && bit_q != 4'h0 |->
		per_q >= 9'h137) else $error("link clock too fast");
	sda_steady_a: assert property (scl && scl_q |->
		$stable(sda_t_oe)) else $error("target moved data with clock high");
endmodule // sirp_asserts

/* dv/sirp_tb_top.sv */
`timescale 1ns/1ps
module sirp_tb_top
	import sirp_pkg::*;
();
	logic        CLK = 1'b0;
	logic        RST = 1'b1;
	logic [3:0]  ADDR = 4'h0;
	logic [15:0] WDATA = 16'h0000;
	logic        WR = 1'b0;
	logic        RD = 1'b0;
	logic        stb = 1'b0;
	logic        irq_e = 1'b0;
	logic [15:0] RDATA;
	logic        IRQ;
	logic [7:0]  rate;
	logic [15:0] v;
	logic [7:0]  ex [17];
	int          errors = 0;
	int          total_checks = 0;
	sirp_if lnk ();
	sirp_host u_sirp_host (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .LINK(lnk.host));
	sirp_target u_sirp_target (.CLK(CLK), .RST(RST), .LINK(lnk.target),
		.SAMPLE_STB(stb), .OP_STATE(8'ha5), .CAL_STATE(8'h3c),
		.SELFTEST(8'h81), .FLAGS(16'hc396), .RATE_HZ(rate));
	sirp_asserts u_sirp_asserts (.CLK(CLK), .RST(RST), .scl_oe(lnk.scl_oe),
		.sda_m_o(lnk.sda_m_o), .sda_m_oe(lnk.sda_m_oe),
		.sda_t_o(lnk.sda_t_o), .sda_t_oe(lnk.sda_t_oe), .scl(lnk.scl),
		.sda(lnk.sda));
	always #4 CLK = ~CLK;
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 v = RDATA;
	endtask
	// one byte on the link, then clear the status
	task automatic xfer(logic [4:0] c, logic [7:0] t, logic nk);
		int i = 0;
		wr(SIRP_C_TX, {8'h00, t});
		wr(SIRP_C_CTRL, {11'h000, c});
		v = 16'h0000;
		// a stop still runs after the byte is done; wait for idle too
		while (v[SIRP_ST_DONE] !== 1'b1 || v[SIRP_ST_BUSY] !== 1'b0)
		begin
			rd(SIRP_C_STAT);
			i++;
			if (i > 5000)
			begin
				errors++;
				summarize();
			end
		end
		if (c[2] && nk !== 1'bx)
			chk("nack", {15'h0000, nk}, {15'h0000, v[SIRP_ST_NACK]});
		chk("irq", {15'h0000, irq_e}, {15'h0000, IRQ});
		wr(SIRP_C_CLR, 16'h0007);
		@(posedge CLK);
		#1 chk("irq clear", 16'h0000, {15'h0000, IRQ});
	endtask
	initial
	begin
		ex = '{8'h19, SIRP_ACCEL_FS, SIRP_GYRO_FS[7:0], SIRP_GYRO_FS[15:8],
			8'ha5, 8'h3c, 8'h81, 8'h96, 8'hc3, 8'h00, 8'h00, 8'h00,
			8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
		repeat (5) @(posedge CLK);
		RST <= 1'b0;
		chk("rate reset", {8'h00, SIRP_RATE_RST}, {8'h00, rate});
		rd(SIRP_C_DIV);
		chk("div reset", SIRP_DIV_RST, v);
		wr(4'hf, 16'hffff);
		rd(SIRP_C_IEN);
		chk("ien", 16'h0000, v);
		wr(SIRP_C_IEN, 16'h0001);
		irq_e = 1'b1;
		xfer(5'h07, {SIRP_TARGET_ADDR ^ 7'h01, 1'b1}, 1'b1);
		xfer(5'h05, {SIRP_TARGET_ADDR, 1'b1}, 1'b0);
		xfer(5'h04, SIRP_REG_RATE, 1'b0);
		xfer(5'h04, 8'h19, 1'b0);
		wr(SIRP_C_IEN, 16'h0000);
		irq_e = 1'b0;
		// next byte lands on a read-only register
		xfer(5'h06, 8'hff, 1'bx);
		chk("rate", 16'h0019, {8'h00, rate});
		repeat (3)
		begin
			@(posedge CLK);
			stb <= 1'b1;
			@(posedge CLK);
			stb <= 1'b0;
		end
		xfer(5'h05, {SIRP_TARGET_ADDR, 1'b1}, 1'b0);
		xfer(5'h06, SIRP_REG_RATE, 1'b0);
		xfer(5'h05, {SIRP_TARGET_ADDR, 1'b0}, 1'b0);
		for (int k = 0; k < 17; k++)
		begin
			xfer(k == 16 ? 5'h1a : 5'h08, 8'h00, 1'bx);
			rd(SIRP_C_RX);
			chk("rx", {8'h00, ex[k]}, {8'h00, v[7:0]});
		end
		summarize();
	end
endmodule // sirp_tb_top
